// File: rtl/pci_sideband_pkg.sv
package pci_sideband_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	// error output delay after detection, in data clocks
	localparam int PERR_DELAY_CLK = 2;
	localparam logic ACTIVE_LOW = 1'h0;
	localparam logic INACTIVE_HIGH = 1'h1;
	localparam int PORT_COUNT = 2;
	localparam int AD_WIDTH = 32;
	localparam int CBE_WIDTH = 4;

	// bus lines as seen on one rising edge of the bus clock
	typedef struct packed {
		logic [AD_WIDTH-1:0] ad;
		logic [CBE_WIDTH-1:0] cbe;
		logic par;
		logic addrPhase;
		logic dataPhase;
		logic specialCycle;
	} bus_sample_t;

	// pin drivers; open-drain pins drive low while the enable is high
	typedef struct packed {
		logic serrOut;
		logic serrOe;
		logic perrOut;
		logic perrOe;
		logic [PORT_COUNT-1:0] intOut;
		logic [PORT_COUNT-1:0] intOe;
		logic pmeOut;
		logic pmeOe;
	} pin_drive_t;
endpackage

// File: rtl/pci_reset_error_pme_sideband.sv
`timescale 1ns/1ps
`default_nettype none
module pci_reset_error_pme_sideband (
	input wire logic clk,
	input wire logic srst,
	input wire logic busResetN,
	input wire logic powerGoodInput,
	input wire logic m66Enable,
	input wire logic auxPowerPresent,
	input wire pci_sideband_pkg::bus_sample_t busIn,
	input wire logic serrEnable,
	input wire logic perrEnable,
	input wire logic [pci_sideband_pkg::PORT_COUNT-1:0] portIrq,
	input wire logic wakeEvent,
	input wire logic pmeEnableWrite,
	input wire logic pmeEnableValue,
	input wire logic pmeStatusClear,
	input wire logic advancedWakeEnable,
	output pci_sideband_pkg::pin_drive_t pins,
	output logic m66Capable,
	output logic d3ColdWakeAdvert,
	output logic pmeEnable,
	output logic pmeStatus
);
	logic busActive;
	logic rstPrev;
	logic releaseEdge;
	logic stateClr;
	logic pmeClr;
	pci_sideband_pkg::bus_sample_t prevBus;
	logic parityBad;
	logic addrParErr;
	logic dataParErr;
	logic serrFire;
	logic [pci_sideband_pkg::PERR_DELAY_CLK-1:0] perrPipe;
	logic perrHigh;
	logic [pci_sideband_pkg::PORT_COUNT-1:0] intReq;

	function automatic logic evenParityBad(input pci_sideband_pkg::bus_sample_t s, input logic par);
		evenParityBad = ^{s.ad, s.cbe, par};
	endfunction

	assign busActive = busResetN && powerGoodInput;
	assign releaseEdge = busResetN && !rstPrev;
	assign stateClr = srst || !powerGoodInput || !busResetN || releaseEdge;
	assign pmeClr = srst || !powerGoodInput;

	// bus reset tracked as a level, outside bus sampling
	always_ff @(posedge clk) begin
		if (srst) begin
			rstPrev <= 1'h0;
		end else begin
			rstPrev <= busResetN;
		end
	end

	// address/data lines held one clock, parity arrives a clock later
	always_ff @(posedge clk) begin
		if (stateClr) begin
			prevBus <= '0;
		end else begin
			prevBus <= busIn;
		end
	end

	assign parityBad = evenParityBad(prevBus, busIn.par);
	assign addrParErr = busActive && prevBus.addrPhase && parityBad;
	assign dataParErr = busActive && perrEnable && prevBus.dataPhase && !prevBus.specialCycle && parityBad;

	always_ff @(posedge clk) begin
		if (stateClr) begin
			serrFire <= 1'h0;
		end else begin
			serrFire <= addrParErr && serrEnable && !serrFire;
		end
	end

	always_ff @(posedge clk) begin
		if (stateClr) begin
			perrPipe <= '0;
			perrHigh <= 1'h0;
		end else begin
			perrPipe <= {perrPipe[pci_sideband_pkg::PERR_DELAY_CLK-2:0], dataParErr};
			perrHigh <= perrPipe[pci_sideband_pkg::PERR_DELAY_CLK-1];
		end
	end

	always_ff @(posedge clk) begin
		if (stateClr) begin
			intReq <= '0;
		end else begin
			intReq <= portIrq;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			m66Capable <= 1'h0;
		end else begin
			m66Capable <= m66Enable;
		end
	end

	// wake context: kept across bus reset only with auxiliary power
	always_ff @(posedge clk) begin
		if (pmeClr || (releaseEdge && !auxPowerPresent)) begin
			pmeEnable <= 1'h0;
		end else if (pmeEnableWrite && busActive) begin
			pmeEnable <= pmeEnableValue;
		end
	end

	always_ff @(posedge clk) begin
		if (pmeClr) begin
			pmeStatus <= 1'h0;
		end else if (wakeEvent) begin
			pmeStatus <= 1'h1; // set beats status clear and release clear; power-good clear beats set
		end else if ((releaseEdge && !auxPowerPresent) || (pmeStatusClear && busActive)) begin
			pmeStatus <= 1'h0;
		end
	end

	assign d3ColdWakeAdvert = auxPowerPresent;

	always_comb begin
		pins.serrOut = pci_sideband_pkg::ACTIVE_LOW;
		pins.serrOe = serrFire && busActive;
		pins.perrOut = perrPipe[pci_sideband_pkg::PERR_DELAY_CLK-1] ? pci_sideband_pkg::ACTIVE_LOW
			: pci_sideband_pkg::INACTIVE_HIGH;
		pins.perrOe = (perrPipe[pci_sideband_pkg::PERR_DELAY_CLK-1] || perrHigh) && busActive;
		pins.intOut = '0;
		pins.intOe = intReq & {pci_sideband_pkg::PORT_COUNT{busActive}};
		pins.pmeOut = pci_sideband_pkg::ACTIVE_LOW;
		pins.pmeOe = powerGoodInput && pmeStatus && (pmeEnable || advancedWakeEnable);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	serr_one_clock_a: assert property (pins.serrOe |=> !pins.serrOe)
		else $error("system error held longer than one clock");
	serr_cause_a: assert property (addrParErr && serrEnable && !serrFire ##1 busActive |-> pins.serrOe)
		else $error("address parity error not reported");
	serr_release_a: assert property ($fell(pins.serrOe) |-> !pins.serrOe ##1 (!pins.serrOe || $past(addrParErr && serrEnable)))
		else $error("system error not released");
	perr_delay_a: assert property (dataParErr ##1 busActive ##1 busActive |-> pins.perrOe && !pins.perrOut)
		else $error("parity error output not active two clocks after detection");
	perr_cause_a: assert property (pins.perrOe && !pins.perrOut |-> $past(dataParErr, 2))
		else $error("parity error output active without a data phase error");
	perr_special_a: assert property (prevBus.specialCycle |-> !dataParErr ##2 !(pins.perrOe && !pins.perrOut)
		|| $past(dataParErr))
		else $error("special cycle reported a parity error");
	reset_float_a: assert property (!busResetN |-> !pins.serrOe && !pins.perrOe && pins.intOe == '0)
		else $error("bus output driven during bus reset");
	pg_float_a: assert property (!powerGoodInput |-> !pins.pmeOe && !pins.serrOe && !pins.perrOe ##1 !pmeStatus)
		else $error("pin driven or state kept while power good low");
	release_clear_a: assert property (releaseEdge |=> perrPipe == '0 && !serrFire && intReq == '0)
		else $error("state not cleared at bus reset release");
	pme_drive_a: assert property (wakeEvent && powerGoodInput ##1 (pmeEnable || advancedWakeEnable) && powerGoodInput
		|-> pins.pmeOe)
		else $error("wake event did not drive the wake output");
	pme_keep_a: assert property (releaseEdge && auxPowerPresent && powerGoodInput && !pmeEnableWrite
		|=> pmeEnable == $past(pmeEnable))
		else $error("wake enable lost across bus reset with auxiliary power");
	pme_drop_a: assert property (releaseEdge && !auxPowerPresent && !wakeEvent |=> !pmeEnable && !pmeStatus)
		else $error("wake context kept without auxiliary power");
	int_level_a: assert property (busActive && $past(busActive) && !$past(releaseEdge)
		|-> pins.intOe == $past(portIrq))
		else $error("interrupt request not following port request");

	// pin floating and driving, state clearing, enable gating and 66 MHz capability
	pg_int_float_a: assert property (!powerGoodInput |-> pins.intOe == '0)
		else $error("interrupt driven while power good low");
	pg_hold_a: assert property (!powerGoodInput |=> !pmeEnable)
		else $error("wake enable kept while power good low");
	reset_clear_a: assert property (!busResetN |=> !serrFire && perrPipe == '0 && intReq == '0)
		else $error("bus input not ignored during bus reset");
	reset_pme_kept_a: assert property (!busResetN && powerGoodInput && pmeStatus && pmeEnable |-> pins.pmeOe)
		else $error("wake output floated during bus reset");
	serr_disabled_a: assert property (!serrEnable |=> !pins.serrOe)
		else $error("system error driven while disabled");
	perr_disabled_a: assert property (!perrEnable ##2 1 |-> !(pins.perrOe && !pins.perrOut))
		else $error("parity error driven while disabled");
	perr_tail_a: assert property (pins.perrOe && !pins.perrOut ##1 busActive |-> pins.perrOe)
		else $error("parity error output floated without driving high");
	m66_follow_a: assert property (!$past(srst) |-> m66Capable == $past(m66Enable))
		else $error("66 MHz capability not following its input");

	// wake context
	pme_gate_a: assert property (!pmeEnable && !advancedWakeEnable |-> !pins.pmeOe)
		else $error("wake output driven with both enables clear");
	pme_status_set_a: assert property (wakeEvent && powerGoodInput |=> pmeStatus)
		else $error("wake event did not set wake status");
	status_keep_a: assert property (releaseEdge && auxPowerPresent && powerGoodInput && !pmeStatusClear
		|=> pmeStatus || !$past(pmeStatus))
		else $error("wake status lost across bus reset with auxiliary power");
	d3_advert_a: assert property ($changed(auxPowerPresent) |-> d3ColdWakeAdvert == auxPowerPresent)
		else $error("cold-sleep advertisement lagging auxiliary power");

	serr_seen_c: cover property (pins.serrOe);
	perr_seen_c: cover property (pins.perrOe && !pins.perrOut ##1 pins.perrOe && pins.perrOut);
	pme_seen_c: cover property (wakeEvent ##1 pins.pmeOe);
	aux_keep_c: cover property (releaseEdge && auxPowerPresent && pmeEnable);
	int_seen_c: cover property (pins.intOe != '0);
endmodule // pci_reset_error_pme_sideband
`default_nettype wire

// File: test/pci_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pci_host_model (
	input wire logic clk,
	input wire logic addrReq,
	input wire logic dataReq,
	input wire logic special,
	input wire logic badPar,
	input wire pci_sideband_pkg::pin_drive_t pins,
	output pci_sideband_pkg::bus_sample_t busIn,
	output logic serrWire,
	output logic perrWire,
	output logic pmeWire,
	output logic [1:0] intWire
);
	logic [35:0] adCbe = 36'h5_a5c3_0f01;
	logic par = 1'h0;
	// lines change every cycle so a stale value never matches by luck
	always_ff @(posedge clk) begin
		adCbe <= adCbe + 36'h1_1111_1111;
		par <= ^adCbe ^ badPar;
	end
	assign busIn = {adCbe, par, addrReq, dataReq, special};
	// board pull-ups on every open-drain or floated line
	assign serrWire = ~pins.serrOe;
	assign perrWire = pins.perrOe ? pins.perrOut : 1'h1;
	assign pmeWire = ~pins.pmeOe;
	assign intWire = ~pins.intOe;
endmodule // pci_host_model
`default_nettype wire

// File: test/pci_reset_error_pme_sideband_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pci_reset_error_pme_sideband_tb;
	logic clk = 0, srst = 1, busResetN = 1, powerGoodInput = 1, m66Enable = 0, auxPowerPresent = 0;
	logic serrEnable = 1, perrEnable = 1, wakeEvent = 0, pmeEnableWrite = 0, pmeEnableValue = 0;
	logic pmeStatusClear = 0, advancedWakeEnable = 0, addrReq = 0, dataReq = 0, special = 0, badPar = 0;
	logic [1:0] portIrq = 2'h0;
	logic [1:0] intWire;
	logic m66Capable, d3ColdWakeAdvert, pmeEnable, pmeStatus, serrWire, perrWire, pmeWire;
	pci_sideband_pkg::bus_sample_t busIn;
	pci_sideband_pkg::pin_drive_t pins;
	int failCount = 0, numChecks = 0, cycles = 0, lows, first;
	always #2.5 clk = ~clk;
	pci_reset_error_pme_sideband pci_reset_error_pme_sideband_inst (.clk, .srst, .busResetN, .powerGoodInput,
		.m66Enable, .auxPowerPresent, .busIn, .serrEnable, .perrEnable, .portIrq, .wakeEvent, .pmeEnableWrite,
		.pmeEnableValue, .pmeStatusClear, .advancedWakeEnable, .pins, .m66Capable, .d3ColdWakeAdvert,
		.pmeEnable, .pmeStatus);
	pci_host_model pci_host_model_inst (.clk, .addrReq, .dataReq, .special, .badPar, .pins, .busIn,
		.serrWire, .perrWire, .pmeWire, .intWire);
	task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
		numChecks++;
		if (got !== exp) begin
			failCount++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// n back-to-back phases, then count low cycles of the error wire
	task automatic phases(input logic isAddr, input logic sp, input int n, input logic bad);
		repeat (n) begin
			@(posedge clk);
			addrReq <= isAddr;
			dataReq <= !isAddr;
			special <= sp;
			badPar <= bad;
		end
		@(posedge clk);
		addrReq <= 0;
		dataReq <= 0;
		special <= 0;
		badPar <= 0;
		lows = 0;
		first = 0;
		for (int k = 1; k < 8; k++) begin
			#1;
			if ((isAddr ? serrWire : perrWire) === 1'h0) begin
				lows++;
				if (first == 0) first = k;
			end
			@(posedge clk);
		end
	endtask
	task automatic finalReport();
		$display("checks %0d mismatches %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			failCount++;
			finalReport();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		#1;
		check("oeInReset", 4'h0, {pins.serrOe, pins.perrOe, pins.pmeOe, |pins.intOe});
		@(posedge clk);
		srst <= 0;
		repeat (3) @(posedge clk);
		phases(1, 0, 1, 1);
		check("serrFirst", 4'h2, first[3:0]);
		check("serrLows", 4'h1, lows[3:0]);
		phases(1, 0, 1, 0);
		check("serrGood", 4'h0, lows[3:0]);
		serrEnable <= 0;
		phases(1, 0, 1, 1);
		check("serrOff", 4'h0, lows[3:0]);
		serrEnable <= 1;
		phases(0, 0, 1, 1);
		check("perrFirst", 4'h3, first[3:0]);
		check("perrLows", 4'h1, lows[3:0]);
		phases(0, 0, 2, 1);
		check("perrTwo", 4'h2, lows[3:0]);
		phases(0, 1, 1, 1);
		check("perrSpecial", 4'h0, lows[3:0]);
		$display("test parity done");
		pmeEnableWrite <= 1;
		pmeEnableValue <= 1;
		wakeEvent <= 1;
		@(posedge clk);
		pmeEnableWrite <= 0;
		wakeEvent <= 0;
		portIrq <= 2'h1;
		auxPowerPresent <= 1;
		busResetN <= 0;
		phases(1, 0, 1, 1);
		check("serrInReset", 4'h0, lows[3:0]);
		check("intInReset", 4'h3, {2'h0, intWire});
		check("pmeInReset", 4'h0, {3'h0, pmeWire});
		check("d3Advert", 4'h1, {3'h0, d3ColdWakeAdvert});
		busResetN <= 1;
		repeat (3) @(posedge clk);
		#1;
		check("pmeKept", 4'h3, {2'h0, pmeEnable, pmeStatus});
		check("intA", 4'h2, {2'h0, intWire});
		@(posedge clk);
		auxPowerPresent <= 0;
		#1;
		check("d3Drop", 4'h0, {3'h0, d3ColdWakeAdvert});
		@(posedge clk);
		busResetN <= 0;
		repeat (2) @(posedge clk);
		busResetN <= 1;
		repeat (3) @(posedge clk);
		#1;
		check("pmeCleared", 4'h1, {pmeEnable, pmeStatus, 1'h0, pmeWire});
		@(posedge clk);
		advancedWakeEnable <= 1;
		wakeEvent <= 1;
		@(posedge clk);
		wakeEvent <= 0;
		@(posedge clk);
		#1;
		check("pmeAdvanced", 4'h0, {3'h0, pmeWire});
		@(posedge clk);
		powerGoodInput <= 0;
		m66Enable <= 1;
		repeat (2) @(posedge clk);
		#1;
		check("pgFloat", 4'h7, {1'h0, pmeWire, intWire});
		check("m66", 4'h1, {3'h0, m66Capable});
		$display("test reset and wake done");
		finalReport();
	end
endmodule // pci_reset_error_pme_sideband_tb
`default_nettype wire
